// [rtl/csfs_card.sv]
`timescale 1ns/1ns
`default_nettype none
module csfs_card #(
  parameter logic [95:0] FN_MASK = 96'h0001_0001_0001_0001_4013_0003, // group 1 low
  parameter logic [15:0] MAX_CUR = 16'h0064,
  parameter logic [7:0]  VERSION = csfs_pkg::VER_V1
) (
  // link
  csfs_if.card              lnk,
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  // busy flags per function, group 1 in the low 16 bits
  input  wire logic [95:0]  fn_busy_i,
  // selection state
  output logic              hs_mode_o,
  output logic [23:0]       fn_sel_o,
  // decoded command towards the card core
  output logic              cmd_valid_o,
  output logic [5:0]        cmd_index_o,
  output logic [31:0]       cmd_arg_o,
  output logic [1:0]        cmd_class_o
);
  // ----------------------------------------------------------------
  // link sampling
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {C_IDLE, C_RX, C_STOP, C_TX} csfs_card_state_e;

  csfs_card_state_e   state_r;      // frame state
  logic [1:0]         sclk_s_r;     // clock synchroniser
  logic [1:0]         cmd_s_r;      // command synchroniser
  logic               sclk_d_r;     // delayed clock for edges
  logic [37:0]        rx_sr_r;      // index and argument
  logic [5:0]         rx_cnt_r;     // bits received
  logic [513:0]       tx_sr_r;      // start, payload, stop
  logic [9:0]         tx_cnt_r;     // bits left to send
  logic               dat_r;        // data line driver
  logic [23:0]        fn_sel_r;     // current function per group
  logic               hs_r;         // high-speed selected
  logic               cv_r;
  logic [5:0]         ci_r;
  logic [31:0]        ca_r;
  logic [1:0]         cc_r;
  logic               rise;
  logic               fall;
  logic               cmd_bit;

  // first stage of each pair feeds only the second
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_s_r <= 2'h0;
      cmd_s_r  <= 2'h3;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], lnk.sclk};
      cmd_s_r  <= {cmd_s_r[0], lnk.cmd};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  assign rise    = sclk_s_r[1] & ~sclk_d_r;
  assign fall    = ~sclk_s_r[1] & sclk_d_r;
  assign cmd_bit = cmd_s_r[1];

  // ----------------------------------------------------------------
  // status codes per group
  // ----------------------------------------------------------------
  function automatic logic [3:0] csfs_code(input logic [3:0]  a,
                                           input logic [15:0] m,
                                           input logic [15:0] b,
                                           input logic [3:0]  cur);
    logic sup;
    sup = |m[15:1];
    if (!sup) begin
      // unsupported group
      csfs_code = (a == csfs_pkg::CODE_DEF || a == csfs_pkg::CODE_ERR) ?
                  csfs_pkg::CODE_DEF : csfs_pkg::CODE_ERR;
    end else if (a == csfs_pkg::CODE_DEF) begin
      csfs_code = csfs_pkg::CODE_DEF;
    end else if (a == csfs_pkg::CODE_ERR) begin
      csfs_code = cur;
    end else if (!m[a]) begin
      csfs_code = csfs_pkg::CODE_ERR;
    end else if (b[a]) begin
      csfs_code = cur;
    end else begin
      csfs_code = a;
    end
  endfunction : csfs_code

  wire [23:0] code_w;   // status codes, group 1 low
  wire [95:0] busy_w;   // busy flags as published
  wire [5:0]  err_w;    // group reports Fh
  wire [5:0]  take_w;   // group would switch in

  genvar g;
  generate
    for (g = 0; g < csfs_pkg::GROUPS; g = g + 1) begin : g_grp
      wire [3:0]  a = rx_sr_r[4*g +: 4];
      wire [15:0] m = FN_MASK[16*g +: 16];
      // the command-system group only carries three busy positions
      if (g == csfs_pkg::CS_GRP) begin : g_cs
        assign busy_w[16*g +: 16] = fn_busy_i[16*g +: 16] & csfs_pkg::CS_BUSY_M;
      end else begin : g_pl
        assign busy_w[16*g +: 16] = fn_busy_i[16*g +: 16];
      end
      assign code_w[4*g +: 4] = csfs_code(a, m, busy_w[16*g +: 16],
                                          fn_sel_r[4*g +: 4]);
      assign err_w[g]  = (code_w[4*g +: 4] == csfs_pkg::CODE_ERR);
      // only the default or ready, implemented functions of a supported group switch
      assign take_w[g] = (|m[15:1]) && (a != csfs_pkg::CODE_ERR) &&
                         (a == csfs_pkg::CODE_DEF ||
                          (m[a] && !busy_w[16*g + a]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // command decode at the stop bit
  // ----------------------------------------------------------------
  logic [5:0]   idx;
  logic         is_sw;
  logic         rsv;
  logic [1:0]   cls;
  logic [511:0] frame;

  assign idx   = rx_sr_r[37:32];
  assign is_sw = (idx == csfs_pkg::CMD_SWITCH);
  assign rsv   = (idx >= csfs_pkg::CMD_RSV_A && idx <= csfs_pkg::CMD_RSV_B) ||
                 idx == csfs_pkg::CMD_RSV_C || idx == csfs_pkg::CMD_RSV_D;

  // reserved commands take their meaning from the command-system group
  always_comb begin
    cls = csfs_pkg::CLS_NORMAL;
    if (rsv) begin
      case (fn_sel_r[4*csfs_pkg::CS_GRP +: 4])
        csfs_pkg::CS_STD:    cls = csfs_pkg::CLS_ILLEG;
        csfs_pkg::CS_MCOM:   cls = csfs_pkg::CLS_MCOM;
        csfs_pkg::CS_VENDOR: cls = csfs_pkg::CLS_VENDOR;
        default:             cls = csfs_pkg::CLS_ILLEG;
      endcase
    end
  end

  // version 00h leaves the busy region undefined, sent as zero
  assign frame = {MAX_CUR, FN_MASK, code_w, VERSION,
                  (VERSION == csfs_pkg::VER_V1) ? busy_w : 96'h0,
                  {csfs_pkg::RSV_W{1'b0}}};

  // ----------------------------------------------------------------
  // frame state machine
  // ----------------------------------------------------------------
  // receive on link rising edges, answer on falling edges
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r  <= C_IDLE;
      rx_sr_r  <= 38'h0;
      rx_cnt_r <= 6'h0;
      tx_sr_r  <= {514{1'b1}};
      tx_cnt_r <= 10'h0;
      dat_r    <= 1'b1;
    end else begin
      case (state_r)
        C_IDLE: begin
          // a low command bit opens a frame
          if (rise && !cmd_bit) begin
            state_r  <= C_RX;
            rx_cnt_r <= 6'h0;
          end
        end
        C_RX: begin
          if (rise) begin
            rx_sr_r  <= {rx_sr_r[36:0], cmd_bit};
            rx_cnt_r <= rx_cnt_r + 6'h1;
            if (rx_cnt_r == 6'(csfs_pkg::RX_BITS - 1)) begin
              state_r <= C_STOP;
            end
          end
        end
        C_STOP: begin
          if (rise) begin
            if (!cmd_bit) begin
              // broken frame is dropped without an answer
              state_r <= C_IDLE;
            end else if (is_sw) begin
              state_r  <= C_TX;
              tx_sr_r  <= {1'b0, frame, 1'b1};
              tx_cnt_r <= 10'(csfs_pkg::LONG_BITS + 2);
            end else begin
              state_r  <= C_TX;
              tx_sr_r  <= {1'b0, cls, hs_r, 1'b1, {509{1'b1}}};
              tx_cnt_r <= 10'(csfs_pkg::SHORT_BITS + 2);
            end
          end
        end
        C_TX: begin
          if (fall) begin
            dat_r    <= tx_sr_r[513];
            tx_sr_r  <= {tx_sr_r[512:0], 1'b1};
            tx_cnt_r <= tx_cnt_r - 10'h1;
            if (tx_cnt_r == 10'h0) begin
              dat_r   <= 1'b1;
              state_r <= C_IDLE;
            end
          end
        end
        default: state_r <= C_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // function selection
  // ----------------------------------------------------------------
  // power-up in default functions, so default speed
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fn_sel_r <= 24'h0;
      hs_r     <= 1'b0;
    end else begin
      // one Fh anywhere cancels the whole switch
      if (state_r == C_STOP && rise && cmd_bit && is_sw &&
          rx_sr_r[csfs_pkg::MODE_BIT] && !(|err_w)) begin
        for (int i = 0; i < csfs_pkg::GROUPS; i++) begin
          if (take_w[i]) begin
            fn_sel_r[4*i +: 4] <= rx_sr_r[4*i +: 4];
          end
        end
      end
      hs_r <= (fn_sel_r[3:0] == csfs_pkg::HS_FN);
    end
  end

  // ----------------------------------------------------------------
  // command report to the core
  // ----------------------------------------------------------------
  // one-cycle pulse for every well-formed command, query included
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cv_r <= 1'b0;
      ci_r <= 6'h0;
      ca_r <= 32'h0;
      cc_r <= 2'h0;
    end else begin
      cv_r <= (state_r == C_STOP) && rise && cmd_bit;
      if (state_r == C_STOP && rise && cmd_bit) begin
        ci_r <= idx;
        ca_r <= rx_sr_r[31:0];
        cc_r <= cls;
      end
    end
  end

  assign lnk.dat     = dat_r;
  assign hs_mode_o   = hs_r;
  assign fn_sel_o    = fn_sel_r;
  assign cmd_valid_o = cv_r;
  assign cmd_index_o = ci_r;
  assign cmd_arg_o   = ca_r;
  assign cmd_class_o = cc_r;
endmodule : csfs_card
`default_nettype wire

// [rtl/csfs_pkg.sv]
package csfs_pkg;
  // ----------------------------------------------------------------
  // command and status layout
  // ----------------------------------------------------------------
  localparam int          GROUPS     = 6;        // function groups
  localparam int          FN_W       = 4;        // code width per group
  localparam int          STAT_W     = 512;      // status structure bits
  localparam int          RX_BITS    = 38;       // index plus argument
  localparam int          MODE_BIT   = 31;       // 1 = switch, 0 = query
  localparam logic [5:0]  CMD_SWITCH = 6'h06;
  localparam logic [3:0]  CODE_DEF   = 4'h0;
  localparam logic [3:0]  CODE_ERR   = 4'hf;
  localparam logic [7:0]  VER_V0     = 8'h00;
  localparam logic [7:0]  VER_V1     = 8'h01;
  localparam int          BUSY_W     = 96;       // bits 367:272
  localparam int          RSV_W      = 272;      // bits 271:0, all zero
  // ----------------------------------------------------------------
  // command-system group (group 2, index 1)
  // ----------------------------------------------------------------
  localparam int          CS_GRP     = 1;
  localparam logic [15:0] CS_BUSY_M  = 16'h4012; // vendor 14, secure 4, ecom 1
  localparam logic [3:0]  CS_STD     = 4'h0;
  localparam logic [3:0]  CS_MCOM    = 4'h1;
  localparam logic [3:0]  CS_VENDOR  = 4'he;
  localparam logic [5:0]  CMD_RSV_A  = 6'h22;    // 34 .. 37
  localparam logic [5:0]  CMD_RSV_B  = 6'h25;
  localparam logic [5:0]  CMD_RSV_C  = 6'h32;    // 50
  localparam logic [5:0]  CMD_RSV_D  = 6'h39;    // 57
  // command classes reported to the user side
  localparam logic [1:0]  CLS_NORMAL = 2'h0;
  localparam logic [1:0]  CLS_ILLEG  = 2'h1;
  localparam logic [1:0]  CLS_MCOM   = 2'h2;
  localparam logic [1:0]  CLS_VENDOR = 2'h3;
  // access-mode group: function 1 is high speed
  localparam logic [3:0]  HS_FN      = 4'h1;
  localparam int          HS_CLK_MHZ = 50;
  localparam int          CORE_MHZ   = 10;
  // response lengths, payload only
  localparam int          LONG_BITS  = 512;
  localparam int          SHORT_BITS = 3;
  // ----------------------------------------------------------------
  // host register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_ARG    = 8'h04;
  localparam logic [7:0]  REG_STAT   = 8'h08;
  localparam logic [7:0]  REG_RESP   = 8'h40;    // 16 words, 511:480 first
  localparam int          CTRL_GO    = 8;
  localparam int          STAT_BUSY  = 0;
  localparam int          STAT_DONE  = 1;
  localparam int          STAT_ILL   = 2;
  localparam int          SCLK_HALF  = 8;        // core cycles per half period
endpackage : csfs_pkg

// [rtl/csfs_if.sv]
`timescale 1ns/1ns
`default_nettype none
// serial link: host makes the clock and command, card answers on data
interface csfs_if;
  logic sclk;  // link clock from host
  logic cmd;   // host to card, idle high
  logic dat;   // card to host, idle high
  modport host (output sclk, output cmd, input dat);
  modport card (input sclk, input cmd, output dat);
endinterface : csfs_if
`default_nettype wire

// [rtl/csfs_host.sv]
`timescale 1ns/1ns
`default_nettype none
module csfs_host #(
  parameter int HALF = csfs_pkg::SCLK_HALF  // core cycles per half link period
) (
  // link, one card only
  csfs_if.host              lnk,
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  // ahb-lite slave
  input  wire logic         hsel_i,
  input  wire logic [31:0]  haddr_i,
  input  wire logic [1:0]   htrans_i,
  input  wire logic         hwrite_i,
  input  wire logic [2:0]   hsize_i,
  input  wire logic [31:0]  hwdata_i,
  input  wire logic         hready_i,
  output logic [31:0]       hrdata_o,
  output logic              hreadyout_o,
  output logic              hresp_o
);
  // ----------------------------------------------------------------
  // link clock divider
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT, H_RECV} csfs_host_state_e;

  csfs_host_state_e state_r;    // transfer state
  logic [7:0]       div_r;      // divider count
  logic             sclk_r;     // link clock
  logic             cmd_r;      // command line
  logic [1:0]       dat_s_r;    // data synchroniser
  logic [39:0]      tx_sr_r;    // outgoing frame
  logic [9:0]       cnt_r;      // bits left
  logic [511:0]     rx_sr_r;    // answer payload
  logic             long_r;     // answer is the status structure
  logic [5:0]       idx_r;      // command index
  logic [31:0]      arg_r;      // command argument
  logic             done_r;     // answer complete, sticky
  logic             go;
  logic             done_set;
  logic             tick;
  logic             rise_nxt;
  logic             fall_nxt;

  assign tick     = (div_r == 8'(HALF - 1));
  assign rise_nxt = tick && !sclk_r;
  assign fall_nxt = tick && sclk_r;

  // free running; a slow core clock keeps it well under 50 MHz
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r  <= 8'h0;
      sclk_r <= 1'b0;
    end else begin
      div_r <= tick ? 8'h0 : div_r + 8'h1;
      if (tick) begin
        sclk_r <= ~sclk_r;
      end
    end
  end

  // first stage feeds only the second
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dat_s_r <= 2'h3;
    end else begin
      dat_s_r <= {dat_s_r[0], lnk.dat};
    end
  end

  // ----------------------------------------------------------------
  // transfer state machine
  // ----------------------------------------------------------------
  // command bits change on falling edges, answer sampled before rising
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= H_IDLE;
      cmd_r   <= 1'b1;
      tx_sr_r <= 40'h0;
      cnt_r   <= 10'h0;
      rx_sr_r <= 512'h0;
      long_r  <= 1'b0;
    end else begin
      case (state_r)
        H_IDLE: begin
          if (go) begin
            // index comes from the write data: idx_r only lands at this same edge
            state_r <= H_SEND;
            tx_sr_r <= {1'b0, hwdata_i[5:0], arg_r, 1'b1};
            cnt_r   <= 10'h28;
            long_r  <= (hwdata_i[5:0] == csfs_pkg::CMD_SWITCH);
          end
        end
        H_SEND: begin
          if (fall_nxt) begin
            if (cnt_r == 10'h0) begin
              cmd_r   <= 1'b1;
              state_r <= H_WAIT;
            end else begin
              cmd_r   <= tx_sr_r[39];
              tx_sr_r <= {tx_sr_r[38:0], 1'b1};
              cnt_r   <= cnt_r - 10'h1;
            end
          end
        end
        H_WAIT: begin
          // no timeout: the card always answers a good frame
          if (rise_nxt && !dat_s_r[1]) begin
            state_r <= H_RECV;
            rx_sr_r <= 512'h0;
            cnt_r   <= long_r ? 10'(csfs_pkg::LONG_BITS) : 10'(csfs_pkg::SHORT_BITS);
          end
        end
        H_RECV: begin
          if (rise_nxt) begin
            rx_sr_r <= {rx_sr_r[510:0], dat_s_r[1]};
            cnt_r   <= cnt_r - 10'h1;
            if (cnt_r == 10'h1) begin
              state_r <= H_IDLE;
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign done_set = (state_r == H_RECV) && rise_nxt && (cnt_r == 10'h1);

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic        acc;        // valid address phase
  logic        wr_pend_r;  // write data phase pending
  logic [7:0]  wr_addr_r;
  logic [31:0] rdata_r;
  logic        rdy_r;
  logic        rsp_r;
  logic [31:0] rd_mux;

  assign acc = hsel_i && hready_i && htrans_i[1];
  assign go  = wr_pend_r && wr_addr_r == csfs_pkg::REG_CTRL && hwdata_i[csfs_pkg::CTRL_GO] &&
               state_r == H_IDLE;

  // read data picked in the address phase, shown in the data phase
  always_comb begin
    rd_mux = 32'h0;
    if (haddr_i[7:6] == csfs_pkg::REG_RESP[7:6]) begin
      rd_mux = rx_sr_r[{~haddr_i[5:2], 5'h0} +: 32];
    end else begin
      case (haddr_i[7:0])
        csfs_pkg::REG_CTRL: rd_mux = {26'h0, idx_r};
        csfs_pkg::REG_ARG:  rd_mux = arg_r;
        csfs_pkg::REG_STAT: rd_mux = {26'h0, rx_sr_r[2:1],
                                      1'b0, (!long_r && rx_sr_r[2:1] == csfs_pkg::CLS_ILLEG),
                                      done_r, (state_r != H_IDLE)};
        default:            rd_mux = 32'h0;
      endcase
    end
  end

  // zero wait states, always okay
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
      rdata_r   <= 32'h0;
      rdy_r     <= 1'b1;
      rsp_r     <= 1'b0;
    end else begin
      wr_pend_r <= acc && hwrite_i;
      if (acc) begin
        wr_addr_r <= haddr_i[7:0];
      end
      if (acc && !hwrite_i) begin
        rdata_r <= rd_mux;
      end
      rdy_r <= 1'b1;
      rsp_r <= 1'b0;
    end
  end

  // writes land in the data phase; a set of done beats its clear
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idx_r  <= 6'h0;
      arg_r  <= 32'h0;
      done_r <= 1'b0;
    end else begin
      if (wr_pend_r && wr_addr_r == csfs_pkg::REG_CTRL) begin
        idx_r <= hwdata_i[5:0];
      end
      if (wr_pend_r && wr_addr_r == csfs_pkg::REG_ARG) begin
        arg_r <= hwdata_i;
      end
      if (done_set) begin
        done_r <= 1'b1;
      end else if (go || (wr_pend_r && wr_addr_r == csfs_pkg::REG_STAT &&
                          hwdata_i[csfs_pkg::STAT_DONE])) begin
        done_r <= 1'b0;
      end
    end
  end

  assign lnk.sclk    = sclk_r;
  assign lnk.cmd     = cmd_r;
  assign hrdata_o    = rdata_r;
  assign hreadyout_o = rdy_r;
  assign hresp_o     = rsp_r;
endmodule : csfs_host
`default_nettype wire

// [sim/csfs_chk.sv]
`timescale 1ns/1ns
`default_nettype none
// watches the serial link between the two ends; the host runs with HALF = 6
module csfs_chk (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // link wires
  input wire logic sclk,
  input wire logic cmd,
  input wire logic dat
);
  // ----------------------------------------------------------------
  // link timing and framing
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // each half period of the link clock lasts HALF core cycles
  sclk_high_hold_a: assert property ($rose(sclk) |-> sclk[*6])
    else $error("link clock high phase too short");
  sclk_low_hold_a: assert property ($fell(sclk) |-> !sclk[*6])
    else $error("link clock low phase too short");
  // the host moves cmd at the very edge that drops the link clock
  cmd_edge_place_a: assert property ($changed(cmd) |-> $fell(sclk))
    else $error("cmd changed away from a link clock fall");
  // a bit stands a whole link period, so no second change soon after
  cmd_bit_hold_a: assert property ($changed(cmd) |=> $stable(cmd)[*8])
    else $error("cmd bit did not stand");
  // the card answers only on falling link clock, after its synchroniser
  dat_edge_place_a: assert property ($changed(dat) |-> !sclk)
    else $error("dat changed while link clock high");
  dat_bit_hold_a: assert property ($changed(dat) |=> $stable(dat)[*8])
    else $error("dat bit did not stand");
  // one talker at a time: card and host never drive low together
  one_talker_a: assert property (!dat |-> cmd)
    else $error("cmd and dat both active");
  // the answer starts only after the stop bit has stood a while
  answer_gap_a: assert property ($fell(dat) |-> $past(cmd, 8) && $past(cmd))
    else $error("answer started inside a command frame");
endmodule : csfs_chk
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // clock, reset, bus and card side signals
  // ----------------------------------------------------------------
  logic        core_clk_i  = 1'b0;   // 10 MHz core clock
  logic        resetn_i    = 1'b0;   // active low reset
  logic        hsel        = 1'b0;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic [95:0] fn_busy     = 96'h0;  // busy flags fed to the card
  wire  logic  hready;               // single slave drives the bus ready
  logic [31:0] hrdata;
  logic        hresp;
  logic        hs_mode;
  logic [23:0] fn_sel;
  logic [5:0]  cmd_index;
  logic [1:0]  cmd_class;
  logic [31:0] cmd_arg;              // argument of the last command
  logic        cmd_valid;            // one pulse per good frame
  int          pulses      = 0;      // cmd_valid pulses seen
  logic [31:0] d;                    // scratch read data
  int          err_total   = 0;
  int          check_count = 0;
  int          cycles      = 0;      // watchdog
  logic [3:0]  fn_t [3] = '{4'he, 4'h1, 4'h0};      // command-system choices
  logic [5:0]  idx_t [3] = '{6'h22, 6'h32, 6'h39};  // reserved commands
  logic [1:0]  cls_t [3] = '{2'h3, 2'h2, 2'h1};     // expected classes

  always #50 core_clk_i = ~core_clk_i;

  csfs_if lnk ();
  // HALF = 6 is the shortest safe link period and keeps the run short
  csfs_host #(.HALF(6)) u_csfs_host (.lnk(lnk), .core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
  csfs_card u_csfs_card (.lnk(lnk), .core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .fn_busy_i(fn_busy), .hs_mode_o(hs_mode), .fn_sel_o(fn_sel), .cmd_valid_o(cmd_valid),
    .cmd_index_o(cmd_index), .cmd_arg_o(cmd_arg), .cmd_class_o(cmd_class));
  csfs_chk u_csfs_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .sclk(lnk.sclk), .cmd(lnk.cmd), .dat(lnk.dat));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one ahb-lite single word transfer; never assumes a wait count
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge core_clk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // start one command and poll until the answer has landed
  task send(input logic [5:0] idx, input logic [31:0] arg);
    logic [31:0] st;
    ahb(1'b1, csfs_pkg::REG_ARG, arg, st);
    ahb(1'b1, csfs_pkg::REG_CTRL, {23'h0, 1'b1, 2'h0, idx}, st);
    st = 32'h0;
    for (int i = 0; i < 3000 && st[1] !== 1'b1; i++) ahb(1'b0, csfs_pkg::REG_STAT, 32'h0, st);
    // an answer that never lands ends the run as a failure
    if (st[1] !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask : send

  task word(input int w, output logic [31:0] wd);
    ahb(1'b0, csfs_pkg::REG_RESP + 8'(4 * w), 32'h0, wd);
  endtask : word

  // switch argument: groups 6..4 always ask for no change
  function automatic logic [31:0] sw(input logic m, input logic [3:0] g3,
                                     input logic [3:0] g2, input logic [3:0] g1);
    return {m, 7'h0, 12'hfff, g3, g2, g1};
  endfunction : sw

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs about 65k cycles
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    // the pulse stands one cycle, so each is seen at exactly one edge
    if (cmd_valid === 1'b1) pulses <= pulses + 1;
    if (cycles == 90000) begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk({8'h0, fn_sel}, 32'h0);
    chk({31'h0, hs_mode}, 32'h0);
    ahb(1'b0, 8'h20, 32'h0, d);
    chk(d, 32'h0);
    // query of a ready function, version 01h, other groups no change
    send(csfs_pkg::CMD_SWITCH, sw(1'b0, 4'hf, 4'hf, 4'h1));
    word(4, d);
    chk(d, 32'h0101_0000);
    chk({8'h0, fn_sel}, 32'h0);
    // same query while busy; busy field of group 2 is masked
    fn_busy <= 96'h0000_0000_0000_0000_ffff_0002;
    send(csfs_pkg::CMD_SWITCH, sw(1'b0, 4'hf, 4'hf, 4'h1));
    word(4, d);
    chk(d, 32'h0001_0000);
    word(6, d);
    chk(d, 32'h0000_4012);
    word(7, d);
    chk(d, 32'h0002_0000);
    fn_busy <= 96'h0;
    // switch into high speed
    send(csfs_pkg::CMD_SWITCH, sw(1'b1, 4'hf, 4'hf, 4'h1));
    word(4, d);
    chk(d, 32'h0101_0000);
    chk({8'h0, fn_sel}, 32'h1);
    chk({31'h0, hs_mode}, 32'h1);
    // one group in error cancels the default switch of group 1
    send(csfs_pkg::CMD_SWITCH, sw(1'b1, 4'hf, 4'h2, 4'h0));
    word(4, d);
    chk(d, 32'hf001_0000);
    chk({8'h0, fn_sel}, 32'h1);
    // switch of a busy function is cancelled
    fn_busy <= 96'h0000_0000_0000_0000_0010_0000;
    send(csfs_pkg::CMD_SWITCH, sw(1'b1, 4'hf, 4'h4, 4'hf));
    word(4, d);
    chk(d, 32'h0101_0000);
    chk({8'h0, fn_sel}, 32'h1);
    fn_busy <= 96'h0;
    // unsupported group asked for a function, masks published
    send(csfs_pkg::CMD_SWITCH, sw(1'b0, 4'h5, 4'hf, 4'hf));
    word(3, d);
    chk(d, 32'h0003_000f);
    // reserved commands under each command-system choice
    for (int i = 0; i < 3; i++) begin
      send(csfs_pkg::CMD_SWITCH, sw(1'b1, 4'hf, fn_t[i], 4'hf));
      send(idx_t[i], 32'h0);
      chk({30'h0, cmd_class}, {30'h0, cls_t[i]});
    end
    ahb(1'b0, csfs_pkg::REG_STAT, 32'h0, d);
    chk(d, 32'h0000_0016);
    word(15, d);
    chk({29'h0, d[2:0]}, 32'h3);
    send(6'h11, 32'h0000_1234);
    chk({30'h0, cmd_class}, 32'h0);
    chk({26'h0, cmd_index}, 32'h11);
    chk(cmd_arg, 32'h0000_1234);
    chk(pulses, 32'hd);
    chk({31'h0, hresp}, 32'h0);
    test_done();
  end
endmodule : tb
`default_nettype wire
